/* File: dsep_comparator_model.sv */
`timescale 1ns/100ps
module dsep_comparator_model #(
  parameter int K_CYC = 40
) (
  input  wire logic       clk_sys,
  input  wire logic       ctrlOut0,
  input  wire logic       ctrlOut1,
  input  wire logic       invSel,
  input  wire logic       logMode,
  input  wire logic       logLvl,
  output logic      [3:0] tcPinIn
);
  logic ctrl;
  logic ctrlPrev;
  logic ended;
  int   waitCnt;

  assign ctrl = ctrlOut0 | ctrlOut1;

  initial
  begin
    ctrlPrev = 1'b0;
    ended = 1'b0;
    waitCnt = -1;
  end

  // Integrator ramps down for a fixed time once the mux flips to reference
  always @(posedge clk_sys)
  begin
    ctrlPrev <= ctrl;
    if (ctrl)
    begin
      ended <= 1'b0;
      waitCnt <= -1;
    end
    else if (ctrlPrev)
      waitCnt <= K_CYC;
    else if (waitCnt > 0)
      waitCnt <= waitCnt - 1;
    else if (waitCnt == 0)
    begin
      ended <= 1'b1;
      waitCnt <= -1;
    end
  end

  // Low at end of conversion, high when inverted wiring is used
  assign tcPinIn = logMode ? {4{logLvl}} : {4{~ended ^ invSel}};
endmodule // dsep_comparator_model

/* File: dsep_defines.svh */
`ifndef DSEP_DEFINES_SVH
`define DSEP_DEFINES_SVH
// Register byte offsets
`define DSEP_OFF_CTRL     8'h00
`define DSEP_OFF_START    8'h04
`define DSEP_OFF_STATUS   8'h08
`define DSEP_OFF_RESULT   8'h0c
`define DSEP_OFF_MAXPER   8'h10
`define DSEP_OFF_LOG      8'h20
// Configuration field positions
`define DSEP_CFG_MODE     0
`define DSEP_CFG_INV      1
`define DSEP_CFG_DED      2
`define DSEP_CFG_PIN_LO   4
`define DSEP_CFG_PS_LO    8
`define DSEP_CFG_EXT      12
// Status field positions
`define DSEP_ST_BUSY      0
`define DSEP_ST_UPD       1
`define DSEP_ST_OVF       2
`define DSEP_ST_IDX_LO    8
// Reset values and log depth
`define DSEP_CFG_RST      16'h0000
`define DSEP_MAXPER_RST   16'hffff
`define DSEP_LOG_DEPTH    8
// Timing
`define DSEP_UNIT_NS      2000
`define DSEP_CLK_MHZ      50
`define DSEP_EXT_REF_MHZ  10
`define DSEP_BASE_CYC     (`DSEP_UNIT_NS * `DSEP_CLK_MHZ / (`DSEP_CLK_MHZ * 1000))
`define DSEP_EXT_CYC      (`DSEP_UNIT_NS * `DSEP_CLK_MHZ / (`DSEP_EXT_REF_MHZ * 1000))
`define DSEP_T_REQO_NS    75600
`define DSEP_T_FIN_NS     82800
`define DSEP_T_ORET_NS    42600
`define DSEP_T_RET_NS     49600
`define DSEP_REQO_CYC     (`DSEP_T_REQO_NS * `DSEP_CLK_MHZ / 1000)
`define DSEP_FIN_CYC      (`DSEP_T_FIN_NS * `DSEP_CLK_MHZ / 1000)
`define DSEP_ORET_CYC     (`DSEP_T_ORET_NS * `DSEP_CLK_MHZ / 1000)
`define DSEP_RET_CYC      (`DSEP_T_RET_NS * `DSEP_CLK_MHZ / 1000)
`endif

/* File: dsep_pkg.sv */
package dsep_pkg;
`include "dsep_defines.svh"

  typedef enum logic [6:0] {
    DSEP_IDLE   = 7'h01,
    DSEP_DELAY  = 7'h02,
    DSEP_FIRST  = 7'h04,
    DSEP_SECOND = 7'h08,
    DSEP_WAIT   = 7'h10,
    DSEP_RUN    = 7'h20,
    DSEP_RET    = 7'h40
  } dsep_state_e;

  typedef logic [15:0] dsep_word_t;

  typedef struct packed {
    dsep_state_e                          state;
    dsep_word_t                           cnt;
    logic [18:0]                          pre;
    dsep_word_t                           ctrlCnt;
    dsep_word_t                           result;
    dsep_word_t                           cfg;
    dsep_word_t                           maxPer;
    logic [12:0]                          lat;
    logic [12:0]                          apbCnt;
    logic [3:0]                           idx;
    logic [3:0]                           want;
    logic [`DSEP_LOG_DEPTH-1:0][15:0]     logMem;
    logic                                 lvlPrev;
    logic                                 discard;
    logic                                 upd;
    logic                                 ovf;
    logic                                 updPulse;
    logic                                 busy;
    logic                                 out0;
    logic                                 out1;
    logic                                 pready;
    logic                                 pslverr;
    logic [31:0]                          prdata;
  } dsep_state_s;
endpackage

/* File: dsep_timer.sv */
`timescale 1ns/100ps
`include "dsep_defines.svh"

// Operation
// RULE1: First integration lasts control count prescaled units
// RULE2: Second integration measured in same units
// RULE3: One counter drives mux, senses comparator
// RULE4: Comparator low level marks end
// RULE5: Inversion option flips comparator input sense
// RULE6: Conversion result is sixteen bits wide
// RULE7: Request with control count starts conversion
// RULE8: Control output toggles 75.6 us after request
// RULE9: Result biased negatively by control count
// RULE10: Update event once result is stored
// RULE11: Dedicated counter second pin, multiplexed first
// RULE12: Prescale 0 to 7, default 0
// RULE13: Run-time prescale overrides; extended 0..15 at 10MHz
// RULE14: Result read answers after 82.8 us
// RULE15: Edge log records high and low periods
// RULE16: Series starts at first rising edge
// RULE17: Any counter overflow stops edge logging
// RULE18: Two consecutive widths at least 104 us
// RULE19: Edge 26.4 us after start gets included
// RULE20: Return 42.6 us overflow, 49.6 us count
// RULE21: Period beyond maximum stops, fewer stored
// RULE22: Maximum period 1 to 65535, default 65535
// RULE23: Edge logging uses both counters
// RULE24: First measurement after reset discarded
// RULE25: Idle, first, second, latch, back to idle
// RULE26: Period is full count, then counter restarts
module dsep_timer #(
  parameter int RD_LAT_CYC = `DSEP_FIN_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  tcPinIn,
  output logic             ctrlOut0,
  output logic             ctrlOut1,
  output logic             updateEvt,
  output logic             busy
);
  import dsep_pkg::*;

  dsep_state_s r;
  dsep_state_s n;
  logic        lvl;
  logic        tick;
  logic        edgeSeen;
  logic        wrAcc;
  logic [32:0] rdWord;

  // Prescaled unit length minus one; legacy range masks the top bit
  function automatic logic [18:0] tcLimit(input dsep_word_t cfg);
    logic [3:0]  ps;
    logic [18:0] base;
    ps = cfg[`DSEP_CFG_EXT] ? cfg[`DSEP_CFG_PS_LO +: 4]
                            : {1'b0, cfg[`DSEP_CFG_PS_LO +: 3]}; // [RULE12]
    base = cfg[`DSEP_CFG_EXT] ? 19'(`DSEP_EXT_CYC)
                              : 19'(`DSEP_BASE_CYC); // [RULE13]
    return 19'(base << ps) - 19'd1; // [RULE1] [RULE2]
  endfunction

  function automatic logic [32:0] rdMux(input dsep_state_s s,
                                        input logic [7:0] a);
    logic [32:0] v;
    v = {1'b1, 32'h0000_0000};
    if (a >= `DSEP_OFF_LOG && a < 8'(`DSEP_OFF_LOG + 4 * `DSEP_LOG_DEPTH)
        && a[1:0] == 2'b00)
      v = {1'b1, 16'h0000, s.logMem[3'(a[4:2])]};
    else
      case (a)
        `DSEP_OFF_CTRL:   v = {1'b1, 16'h0000, s.cfg};
        `DSEP_OFF_START:  v = {1'b1, 16'h0000, s.ctrlCnt};
        `DSEP_OFF_STATUS: v = {1'b1, 20'h00000, s.idx, 5'h00, s.ovf,
                               s.upd, s.busy};
        `DSEP_OFF_RESULT: v = {1'b1, 16'h0000, s.result};
        `DSEP_OFF_MAXPER: v = {1'b1, 16'h0000, s.maxPer};
        default:          v = {1'b0, 32'h0000_0000};
      endcase
    return v;
  endfunction

  // Comparator sense, optionally inverted; upper pins force mux counter
  assign lvl = tcPinIn[r.cfg[`DSEP_CFG_PIN_LO +: 2]]
               ^ r.cfg[`DSEP_CFG_INV]; // [RULE5] [RULE3]
  assign tick     = (r.pre == tcLimit(r.cfg));
  assign edgeSeen = (lvl != r.lvlPrev);
  assign wrAcc    = psel & penable & pwrite & r.pready;
  assign rdWord   = rdMux(r, paddr);

  always_comb
  begin
    logic useDed;
    logic hi;
    useDed = 1'b0;
    hi = 1'b0;
    n = r;
    n.lvlPrev  = lvl;
    n.updPulse = 1'b0;
    n.pready   = 1'b0;
    n.pslverr  = 1'b0;
    n.pre      = tick ? 19'd0 : r.pre + 19'd1;

    // One wait state; result reads are held for the read latency
    if (psel && penable && !r.pready)
    begin
      if (!pwrite && paddr == `DSEP_OFF_RESULT
          && r.apbCnt != 13'(RD_LAT_CYC - 1))
        n.apbCnt = r.apbCnt + 13'd1; // [RULE14]
      else
      begin
        n.apbCnt  = 13'd0;
        n.pready  = 1'b1;
        n.prdata  = pwrite ? 32'h0000_0000 : rdWord[31:0];
        n.pslverr = ~rdWord[32];
      end
    end

    if (wrAcc)
      case (paddr)
        `DSEP_OFF_CTRL:
          if (!r.busy)
            n.cfg = pwdata[15:0]; // [RULE13]
        `DSEP_OFF_MAXPER:
          n.maxPer = (pwdata[15:0] == 16'h0000) ? 16'h0001
                                                : pwdata[15:0]; // [RULE22]
        `DSEP_OFF_STATUS:
        begin
          if (pwdata[`DSEP_ST_UPD])
            n.upd = 1'b0;
          if (pwdata[`DSEP_ST_OVF])
            n.ovf = 1'b0;
        end
        default:
          n.cfg = n.cfg;
      endcase

    case (r.state)
      DSEP_IDLE:
        // Starts while busy are dropped; edge log holds both counters
        if (wrAcc && paddr == `DSEP_OFF_START) // [RULE23]
        begin
          if (!r.cfg[`DSEP_CFG_MODE])
          begin
            n.ctrlCnt = pwdata[15:0]; // [RULE7]
            n.lat     = 13'(`DSEP_REQO_CYC - 1);
            n.state   = DSEP_DELAY; // [RULE25]
          end
          else
          begin
            n.want  = (pwdata[15:0] == 16'h0000) ? 4'd1 :
                      (pwdata[15:0] > 16'(`DSEP_LOG_DEPTH))
                      ? 4'(`DSEP_LOG_DEPTH) : pwdata[3:0];
            n.idx   = 4'd0;
            n.ovf   = 1'b0;
            n.state = DSEP_WAIT;
          end
        end
      DSEP_DELAY:
        if (r.lat == 13'd0)
        begin
          n.state = DSEP_FIRST; // [RULE8]
          n.cnt   = 16'h0000;
          n.pre   = 19'd0;
        end
        else
          n.lat = r.lat - 13'd1;
      DSEP_FIRST:
        if (tick)
        begin
          n.cnt = r.cnt + 16'h0001;
          if (r.cnt == r.ctrlCnt - 16'h0001)
          begin
            n.state = DSEP_SECOND; // [RULE1] [RULE25]
            n.cnt   = 16'h0000;
          end
        end
      DSEP_SECOND:
        if (!lvl) // [RULE4]
        begin
          n.state = DSEP_IDLE; // [RULE25]
          if (r.discard)
            n.discard = 1'b0; // [RULE24]
          else
          begin
            n.result   = r.cnt - r.ctrlCnt; // [RULE2] [RULE6] [RULE9]
            n.upd      = 1'b1; // [RULE10]
            n.updPulse = 1'b1;
          end
        end
        else if (tick)
        begin
          n.cnt = r.cnt + 16'h0001;
          if (r.cnt == 16'hffff)
          begin
            n.ovf   = 1'b1;
            n.state = DSEP_IDLE;
          end
        end
      DSEP_WAIT:
        if (lvl && !r.lvlPrev)
        begin
          n.state = DSEP_RUN; // [RULE16]
          n.cnt   = 16'h0000;
          n.pre   = 19'd0;
        end
      DSEP_RUN:
        if (edgeSeen)
        begin
          n.cnt = 16'h0000; // [RULE26]
          n.pre = 19'd0;
          if (r.discard)
            n.discard = 1'b0; // [RULE24]
          else
          begin
            n.logMem[r.idx[2:0]] = r.cnt; // [RULE15] [RULE26]
            n.idx = r.idx + 4'd1;
            if (r.idx + 4'd1 == r.want)
            begin
              n.lat   = 13'(`DSEP_RET_CYC - 1); // [RULE20]
              n.state = DSEP_RET;
            end
          end
        end
        else if (tick)
        begin
          n.cnt = r.cnt + 16'h0001;
          // Covers both the limit and a full 16-bit wrap
          if (r.cnt >= r.maxPer)
          begin
            n.ovf   = 1'b1; // [RULE17] [RULE21]
            n.lat   = 13'(`DSEP_ORET_CYC - 1); // [RULE20]
            n.state = DSEP_RET;
          end
        end
      DSEP_RET:
        if (r.lat == 13'd0)
          n.state = DSEP_IDLE;
        else
          n.lat = r.lat - 13'd1;
      default:
        n.state = DSEP_IDLE;
    endcase

    useDed = r.cfg[`DSEP_CFG_DED]
             && r.cfg[`DSEP_CFG_PIN_LO +: 2] == 2'b00; // [RULE11]
    hi     = (n.state == DSEP_FIRST); // [RULE3]
    n.out1 = hi & useDed; // [RULE11]
    n.out0 = hi & ~useDed;
    n.busy = (n.state != DSEP_IDLE);
  end

  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      r         <= '0;
      r.state   <= DSEP_IDLE;
      r.cfg     <= `DSEP_CFG_RST; // [RULE12]
      r.maxPer  <= `DSEP_MAXPER_RST; // [RULE22]
      r.discard <= 1'b1;
    end
    else
      r <= n;

  assign prdata    = r.prdata;
  assign pready    = r.pready;
  assign pslverr   = r.pslverr;
  assign ctrlOut0  = r.out0;
  assign ctrlOut1  = r.out1;
  assign updateEvt = r.updPulse;
  assign busy      = r.busy;

  // Cycles spent in the current state, for the checks below
  logic [12:0] dwell;
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      dwell <= 13'd0;
    else if (n.state != r.state)
      dwell <= 13'd0;
    else if (dwell != 13'h1fff)
      dwell <= dwell + 13'd1;

  property p_reqDelay;
    @(posedge clk_sys) disable iff (!reset_n)
    (r.state == DSEP_DELAY && n.state == DSEP_FIRST)
      |-> dwell == 13'(`DSEP_REQO_CYC - 1);
  endproperty
  a_reqDelay: assert property (p_reqDelay) // [RULE8]
    else $error("control output toggle latency wrong");

  property p_firstLen;
    @(posedge clk_sys) disable iff (!reset_n)
    (r.state == DSEP_FIRST ##1 r.state == DSEP_SECOND)
      |-> $past(r.cnt) == r.ctrlCnt - 16'h0001 && $past(tick);
  endproperty
  a_firstLen: assert property (p_firstLen) // [RULE1]
    else $error("first integration ended at wrong count");

  property p_ctrlPin;
    @(posedge clk_sys) disable iff (!reset_n)
    (r.state == DSEP_FIRST) == (ctrlOut0 | ctrlOut1);
  endproperty
  a_ctrlPin: assert property (p_ctrlPin) // [RULE3]
    else $error("control output disagrees with integration phase");

  property p_dedPin;
    @(posedge clk_sys) disable iff (!reset_n)
    (r.cfg[`DSEP_CFG_DED] && r.cfg[`DSEP_CFG_PIN_LO +: 2] == 2'b00)
      |-> !ctrlOut0;
  endproperty
  a_dedPin: assert property (p_dedPin) // [RULE11]
    else $error("dedicated counter drove the first output pin");

  property p_result;
    @(posedge clk_sys) disable iff (!reset_n)
    updateEvt |-> r.upd && r.state == DSEP_IDLE
      && r.result == $past(r.cnt) - r.ctrlCnt;
  endproperty
  a_result: assert property (p_result) // [RULE9]
    else $error("update without biased result in place");

  property p_eoc;
    @(posedge clk_sys) disable iff (!reset_n)
    (r.state == DSEP_SECOND && !lvl) |=> r.state == DSEP_IDLE;
  endproperty
  a_eoc: assert property (p_eoc) // [RULE4]
    else $error("end of conversion not honoured");

  property p_discard;
    @(posedge clk_sys) disable iff (!reset_n)
    (r.discard && r.state == DSEP_SECOND && !lvl) |=> !updateEvt;
  endproperty
  a_discard: assert property (p_discard) // [RULE24]
    else $error("first measurement after reset was reported");

  property p_start;
    @(posedge clk_sys) disable iff (!reset_n)
    (r.state == DSEP_WAIT && lvl && !r.lvlPrev)
      |=> r.state == DSEP_RUN ##1 r.cnt == 16'h0000 || edgeSeen;
  endproperty
  a_start: assert property (p_start) // [RULE16]
    else $error("edge log did not start on rising edge");

  property p_maxStop;
    @(posedge clk_sys) disable iff (!reset_n)
    (r.state == DSEP_RUN && !edgeSeen && tick && r.cnt >= r.maxPer)
      |=> r.state == DSEP_RET && r.ovf
          && r.lat == 13'(`DSEP_ORET_CYC - 1);
  endproperty
  a_maxStop: assert property (p_maxStop) // [RULE21]
    else $error("period limit did not stop the log");

  property p_store;
    @(posedge clk_sys) disable iff (!reset_n)
    (r.state == DSEP_RUN && edgeSeen && !r.discard)
      |=> r.logMem[$past(r.idx[2:0])] == $past(r.cnt) && r.cnt == 16'h0000;
  endproperty
  a_store: assert property (p_store) // [RULE26]
    else $error("period not stored at terminating edge");

  property p_maxPer;
    @(posedge clk_sys) disable iff (!reset_n)
    r.maxPer != 16'h0000;
  endproperty
  a_maxPer: assert property (p_maxPer) // [RULE22]
    else $error("maximum period reached zero");
endmodule // dsep_timer

/* File: dsep_timer_tb.sv */
`timescale 1ns/100ps
`include "dsep_defines.svh"
module dsep_timer_tb;
  localparam int K_CYC = 40;
  logic        clk_sys;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  tcPinIn;
  logic        ctrlOut0;
  logic        ctrlOut1;
  logic        updateEvt;
  logic        busy;
  logic        invSel;
  logic        logMode;
  logic        logLvl;
  logic [31:0] rd;
  logic        err;
  int          errors;
  int          n_compared;
  // Prescale 9 without the extended bit must act as 1
  logic [15:0] tCfg [5] = '{16'h0000, 16'h0000, 16'h0904, 16'h1002, 16'h0714};
  logic [15:0] tCnt [5] = '{16'h0005, 16'h0005, 16'h0003, 16'h0002, 16'h0001};
  int          tUnit [5] = '{2, 2, 4, 10, 256};

  dsep_timer #(.RD_LAT_CYC(4)) dsep_timer_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tcPinIn(tcPinIn),
    .ctrlOut0(ctrlOut0), .ctrlOut1(ctrlOut1), .updateEvt(updateEvt),
    .busy(busy)
  );

  dsep_comparator_model #(.K_CYC(K_CYC)) dsep_comparator_model_inst (
    .clk_sys(clk_sys), .ctrlOut0(ctrlOut0), .ctrlOut1(ctrlOut1),
    .invSel(invSel), .logMode(logMode), .logLvl(logLvl), .tcPinIn(tcPinIn)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic near(input string nm, input int e, input logic [31:0] g,
                      input int tol);
    n_compared++;
    if ($isunknown(g) || g > e + tol || g + tol < e)
    begin
      errors++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim)
    begin
      errors++;
      $display("ERROR wait expected %0d seen %0d", lim, n);
      results();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 6000);
    bound(n, 6000);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic waitIdle(input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end while (busy === 1'b1 && n < lim);
    bound(n, lim);
  endtask

  task automatic conv(input int i, input logic expUpd);
    logic ded;
    logic bad;
    logic upd;
    int   n;
    ded = tCfg[i][2] && tCfg[i][5:4] == 2'b00;
    bad = 1'b0;
    upd = 1'b0;
    invSel <= tCfg[i][1];
    apb(1'b1, `DSEP_OFF_CTRL, {16'h0000, tCfg[i]});
    apb(1'b1, `DSEP_OFF_START, {16'h0000, tCnt[i]});
    n = 0;
    while ((ded ? ctrlOut1 : ctrlOut0) !== 1'b1 && n < 5000)
    begin
      @(posedge clk_sys);
      n++;
    end
    bound(n, 5000);
    near("reqLatency", 3781, n, 2);
    cmp("busy", 32'h1, busy);
    n = 0;
    while ((ded ? ctrlOut1 : ctrlOut0) === 1'b1 && n < 70000)
    begin
      if ((ded ? ctrlOut0 : ctrlOut1) !== 1'b0)
        bad = 1'b1;
      @(posedge clk_sys);
      n++;
    end
    cmp("firstPhase", tCnt[i] * tUnit[i], n);
    cmp("otherOut", 32'h0, bad);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (updateEvt === 1'b1)
        upd = 1'b1;
    end while (busy === 1'b1 && n < 3000);
    bound(n, 3000);
    cmp("update", expUpd, upd);
    apb(1'b0, `DSEP_OFF_RESULT, 32'h0);
    if (expUpd)
      near("result", K_CYC / tUnit[i], (rd + tCnt[i]) & 32'hffff, 2);
    else
      cmp("discarded", 32'h0, rd);
  endtask

  initial
  begin
    errors = 0;
    n_compared = 0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    invSel = 1'b0;
    logMode = 1'b0;
    logLvl = 1'b0;
    tick(12);
    reset_n <= 1'b1;
    apb(1'b0, `DSEP_OFF_CTRL, 32'h0);
    cmp("ctrlReset", 32'h0, rd);
    apb(1'b0, `DSEP_OFF_MAXPER, 32'h0);
    cmp("maxperReset", 32'hffff, rd);
    apb(1'b0, 8'h40, 32'h0);
    cmp("slverr", 32'h1, err);
    cmp("unmappedData", 32'h0, rd);
    for (int i = 0; i < 5; i++)
      conv(i, i != 0);
    // Edge log: high 1300 units, low 1500 units
    invSel <= 1'b0;
    logMode <= 1'b1;
    apb(1'b1, `DSEP_OFF_CTRL, 32'h1);
    apb(1'b1, `DSEP_OFF_START, 32'h2);
    tick(1400);
    logLvl <= 1'b1;
    tick(2600);
    logLvl <= 1'b0;
    tick(3000);
    logLvl <= 1'b1;
    waitIdle(8000);
    apb(1'b0, `DSEP_OFF_LOG, 32'h0);
    near("log0", 1300, rd, 2);
    apb(1'b0, `DSEP_OFF_LOG + 8'h04, 32'h0);
    near("log1", 1500, rd, 2);
    apb(1'b0, `DSEP_OFF_STATUS, 32'h0);
    cmp("stored", 32'h2, rd[11:8]);
    // Overflow ends the series early
    apb(1'b1, `DSEP_OFF_MAXPER, 32'h0);
    apb(1'b0, `DSEP_OFF_MAXPER, 32'h0);
    cmp("maxperMin", 32'h1, rd);
    apb(1'b1, `DSEP_OFF_MAXPER, 32'h10);
    apb(1'b1, `DSEP_OFF_STATUS, 32'h6);
    logLvl <= 1'b0;
    apb(1'b1, `DSEP_OFF_START, 32'h3);
    tick(1400);
    logLvl <= 1'b1;
    waitIdle(6000);
    apb(1'b0, `DSEP_OFF_STATUS, 32'h0);
    cmp("ovfStatus", 32'h4, rd);
    results();
  end
endmodule // dsep_timer_tb
